//--- verilog/ptmr_defines.vh
// register map, field positions and reset values of the periodic timer
`ifndef PTMR_DEFINES_VH
`define PTMR_DEFINES_VH
`define PTMR_ADDR_W 3
`define PTMR_OFS_CTRL0 3'h0
`define PTMR_OFS_CTRL1 3'h1
`define PTMR_OFS_CNT_LO 3'h2
`define PTMR_OFS_CNT_HI 3'h3
`define PTMR_OFS_CMPA_LO 3'h4
`define PTMR_OFS_CMPA_HI 3'h5
`define PTMR_OFS_PER_LO 3'h6
`define PTMR_OFS_PER_HI 3'h7
`define PTMR_CTRL0_RST 8'h00
`define PTMR_CTRL1_RST 8'h00
`define PTMR_PAUSE_BIT 7
`define PTMR_CKSEL_HI 6
`define PTMR_CKSEL_LO 4
`define PTMR_ON_BIT 3
`define PTMR_MODE_HI 7
`define PTMR_MODE_LO 6
`define PTMR_ACT_HI 5
`define PTMR_ACT_LO 4
`define PTMR_INIT_BIT 3
`define PTMR_INV_BIT 2
`define PTMR_CLRSEL_BIT 0
`define PTMR_MODE_CMP 2'b00
`define PTMR_MODE_PWM 2'b10
`define PTMR_MODE_TMR 2'b11
`define PTMR_ACT_00 2'b00
`define PTMR_ACT_01 2'b01
`define PTMR_ACT_10 2'b10
`define PTMR_ACT_11 2'b11
`define PTMR_CK_SYS4 3'b000
`define PTMR_CK_SYS 3'b001
`define PTMR_CK_H16 3'b010
`define PTMR_CK_H64 3'b011
`define PTMR_CK_PINR 3'b110
`define PTMR_CK_PINF 3'b111
`define PTMR_DIV_SYS4 4
`define PTMR_DIV_H16 16
`define PTMR_DIV_H64 64
`define PTMR_DIV_SUB 6100
`endif

//--- verilog/ptmr_sync.v
// two-flop synchroniser for the external clock pin
`timescale 1ns/1ps
module ptmr_sync (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // async level in, synced level out
   input wire d_i,
   output wire q_o
);
   reg meta_ff;
   reg sync_ff;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end
   assign q_o = sync_ff;
endmodule // ptmr_sync

//--- verilog/ptmr_tick.v
// prescaler: one-cycle tick every DIV cycles
`timescale 1ns/1ps
module ptmr_tick #(
   parameter DIV = 4
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // tick output
   output wire tick_o
);
   reg [15:0] cnt_ff;
   wire wrap = (cnt_ff == DIV[15:0] - 16'h0001);
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= wrap ? 16'h0000 : cnt_ff + 16'h0001;
      end
   end
   assign tick_o = wrap;
endmodule // ptmr_tick

//--- verilog/ptmr_timer.v
// 10-bit periodic timer with compare A / period P, four modes
//
// Operation
// - mode field picks compare, timer, PWM/pulse
// - clear-select low: clear on P or overflow
// - clear-select high: clear on A only
// - compare A zero: run to 3FF, no flag
// - compare mode: pin acts only on A match
// - counter-on rise loads pin initial level
// - timer mode like compare, pin unused
// - PWM: period clears, compare A sets duty
// - period 1..1023 clocks, zero gives 1024
// - duty at or above period: full duty
// - PWM raises both flags on matches, pulse raises flag A only
// - PWM initial level, action, invert bit
// - PWM counting continues while pin forced
// - counter-on rise or pin edge starts pulse
// - A match or clear ends pulse
// - pulse: counter zeroed only on start
// - compare A split low/high bytes
// - period split low/high bytes
// - compare action: none, low, high, toggle
// - counter-on rise zeroes, fall holds count
// - PWM action 00 inactive, 01 active
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "ptmr_defines.vh"
module ptmr_timer #(
   parameter SUB_DIV = `PTMR_DIV_SUB
) (
   // clock and reset
   input wire SYS_CLK_I,
   input wire RST_I,
   // register port
   input wire [`PTMR_ADDR_W-1:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output reg [7:0] RDATA_O,
   // pins
   input wire EXT_CLK_PIN_I,
   output reg TIMER_OUT_O,
   output wire TIMER_OUT_EN_O,
   // event flags
   output reg CMP_A_FLAG_O,
   output reg CMP_P_FLAG_O,
   input wire CMP_A_FLAG_CLR_I,
   input wire CMP_P_FLAG_CLR_I
);
   reg [7:0] ctrl0_ff;
   reg [7:0] ctrl1_ff;
   reg [9:0] cmpa_ff;
   reg [9:0] per_ff;
   reg [9:0] cnt_ff;
   reg on_prev_ff;
   reg pin_prev_ff;
   reg level_ff;
   reg [9:0] nxt_cnt;
   reg nxt_level;
   reg nxt_on;
   reg set_a;
   reg set_p;
   wire pin_sync;
   wire tick_sys4;
   wire tick_h16;
   wire tick_h64;
   wire tick_sub;
   reg tick;

   wire [1:0] mode = ctrl1_ff[`PTMR_MODE_HI:`PTMR_MODE_LO];
   wire [1:0] act = ctrl1_ff[`PTMR_ACT_HI:`PTMR_ACT_LO];
   wire init_lvl = ctrl1_ff[`PTMR_INIT_BIT];
   wire inv = ctrl1_ff[`PTMR_INV_BIT];
   wire clr_sel = ctrl1_ff[`PTMR_CLRSEL_BIT];
   wire on_bit = ctrl0_ff[`PTMR_ON_BIT];
   wire paused = ctrl0_ff[`PTMR_PAUSE_BIT];
   wire [2:0] cksel = ctrl0_ff[`PTMR_CKSEL_HI:`PTMR_CKSEL_LO];
   wire on_rise = on_bit & ~on_prev_ff;
   wire pin_rise = pin_sync & ~pin_prev_ff;
   wire pin_fall = ~pin_sync & pin_prev_ff;
   wire pwm_mode = (mode == `PTMR_MODE_PWM);
   wire pulse_mode = pwm_mode & (act == `PTMR_ACT_11);
   wire cmp_like = (mode == `PTMR_MODE_CMP) | (mode == `PTMR_MODE_TMR);
   wire wr_ctrl0 = WR_I & (ADDR_I == `PTMR_OFS_CTRL0);
   wire [7:0] wdata_ctrl0 = wr_ctrl0 ? WDATA_I : ctrl0_ff;

   ptmr_sync u_pin_sync (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .d_i(EXT_CLK_PIN_I),
      .q_o(pin_sync)
   );
   ptmr_tick #(.DIV(`PTMR_DIV_SYS4)) u_tick_sys4 (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .tick_o(tick_sys4)
   );
   ptmr_tick #(.DIV(`PTMR_DIV_H16)) u_tick_h16 (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .tick_o(tick_h16)
   );
   ptmr_tick #(.DIV(`PTMR_DIV_H64)) u_tick_h64 (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .tick_o(tick_h64)
   );
   ptmr_tick #(.DIV(SUB_DIV)) u_tick_sub (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .tick_o(tick_sub)
   );

   always @* begin
      case (cksel)
         `PTMR_CK_SYS4: tick = tick_sys4;
         `PTMR_CK_SYS: tick = 1'b1;
         `PTMR_CK_H16: tick = tick_h16;
         `PTMR_CK_H64: tick = tick_h64;
         `PTMR_CK_PINR: tick = pin_rise;
         `PTMR_CK_PINF: tick = pin_fall;
         default: tick = tick_sub;
      endcase
   end

   // external edge for the pulse trigger follows the selected pin polarity
   wire pin_edge = (cksel == `PTMR_CK_PINF) ? pin_fall : pin_rise;

   // comparator matches, evaluated on the count after the increment
   wire [9:0] cnt_inc = cnt_ff + 10'h001;
   wire match_a = (cnt_inc == cmpa_ff) & (cmpa_ff != 10'h000);
   wire ovf = (cnt_ff == 10'h3FF);
   // zero period: wrap from 3FF counts as P match
   wire match_p = (per_ff == 10'h000) ? ovf : (cnt_inc == per_ff);
   wire run = on_bit & ~paused & tick;

   // pwm duty: active while count below compare A, full when A >= period
   wire [10:0] per_len = (per_ff == 10'h000) ? 11'h400 : {1'b0, per_ff};
   // full duty when duty >= period
   wire duty_act = ({1'b0, cnt_ff} < {1'b0, cmpa_ff}) | ({1'b0, cmpa_ff} >= per_len);

   always @* begin
      nxt_cnt = cnt_ff;
      nxt_level = level_ff;
      nxt_on = wdata_ctrl0[`PTMR_ON_BIT];
      set_a = 1'b0;
      set_p = 1'b0;
      if (on_rise) begin
         nxt_cnt = 10'h000;
         nxt_level = init_lvl;
      end else if (run) begin
         nxt_cnt = cnt_inc;
         if (cmp_like) begin
            if (!clr_sel) begin
               set_p = match_p;
               if (match_p) begin
                  nxt_cnt = 10'h000;
               end
            // clear-select high clears on A, no P flag
            end else if (match_a) begin
               nxt_cnt = 10'h000;
            end
            set_a = match_a;
            // pin acts on A match only
            if (match_a && mode == `PTMR_MODE_CMP) begin
               case (act)
                  `PTMR_ACT_01: nxt_level = 1'b0;
                  `PTMR_ACT_10: nxt_level = 1'b1;
                  `PTMR_ACT_11: nxt_level = ~level_ff;
                  default: nxt_level = level_ff;
               endcase
            end
         end else if (pulse_mode) begin
            // A match ends pulse, clears counter-on
            // no period clear in pulse mode
            set_a = match_a;
            if (match_a) begin
               nxt_on = 1'b0;
            end
         end else if (pwm_mode) begin
            set_a = match_a;
            set_p = match_p;
            if (match_p) begin
               nxt_cnt = 10'h000;
            end
         end
         // overflow wraps naturally through 3FF to 000
         if (ovf && !(cmp_like && clr_sel && match_a)) begin
            nxt_cnt = 10'h000;
         end
      end
      if (pulse_mode && pin_edge && !on_bit) begin
         nxt_on = 1'b1;
      end
   end

   // registers and flags
   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl0_ff <= `PTMR_CTRL0_RST;
         ctrl1_ff <= `PTMR_CTRL1_RST;
         cmpa_ff <= 10'h000;
         per_ff <= 10'h000;
         cnt_ff <= 10'h000;
         on_prev_ff <= 1'b0;
         pin_prev_ff <= 1'b0;
         level_ff <= 1'b0;
         CMP_A_FLAG_O <= 1'b0;
         CMP_P_FLAG_O <= 1'b0;
      end else begin
         ctrl0_ff <= {wdata_ctrl0[7:4], nxt_on, 3'b000};
         if (WR_I) begin
            case (ADDR_I)
               `PTMR_OFS_CTRL1: ctrl1_ff <= {WDATA_I[7:2], 1'b0, WDATA_I[0]};
               `PTMR_OFS_CMPA_LO: cmpa_ff[7:0] <= WDATA_I;
               `PTMR_OFS_CMPA_HI: cmpa_ff[9:8] <= WDATA_I[1:0];
               `PTMR_OFS_PER_LO: per_ff[7:0] <= WDATA_I;
               `PTMR_OFS_PER_HI: per_ff[9:8] <= WDATA_I[1:0];
               default: ;
            endcase
         end
         cnt_ff <= nxt_cnt;
         on_prev_ff <= on_bit;
         pin_prev_ff <= pin_sync;
         level_ff <= nxt_level;
         // set wins over clear
         CMP_A_FLAG_O <= set_a | (CMP_A_FLAG_O & ~CMP_A_FLAG_CLR_I);
         CMP_P_FLAG_O <= set_p | (CMP_P_FLAG_O & ~CMP_P_FLAG_CLR_I);
      end
   end

   // read port: data one cycle after strobe
   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= 8'h00;
      end else if (RD_I) begin
         case (ADDR_I)
            `PTMR_OFS_CTRL0: RDATA_O <= ctrl0_ff;
            `PTMR_OFS_CTRL1: RDATA_O <= ctrl1_ff;
            `PTMR_OFS_CNT_LO: RDATA_O <= cnt_ff[7:0];
            `PTMR_OFS_CNT_HI: RDATA_O <= {6'h00, cnt_ff[9:8]};
            `PTMR_OFS_CMPA_LO: RDATA_O <= cmpa_ff[7:0];
            `PTMR_OFS_CMPA_HI: RDATA_O <= {6'h00, cmpa_ff[9:8]};
            `PTMR_OFS_PER_LO: RDATA_O <= per_ff[7:0];
            default: RDATA_O <= {6'h00, per_ff[9:8]};
         endcase
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   // output pin composition
   reg pin_raw;
   always @* begin
      pin_raw = level_ff;
      if (pwm_mode) begin
         case (act)
            `PTMR_ACT_00: pin_raw = ~init_lvl;
            `PTMR_ACT_01: pin_raw = init_lvl;
            `PTMR_ACT_10: pin_raw = (on_bit & duty_act) ? init_lvl : ~init_lvl;
            default: pin_raw = on_bit ? init_lvl : ~init_lvl;
         endcase
      end
   end

   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         TIMER_OUT_O <= 1'b0;
      end else begin
         TIMER_OUT_O <= pin_raw ^ inv;
      end
   end

   // timer mode leaves the pin free
   assign TIMER_OUT_EN_O = (mode != `PTMR_MODE_TMR);
endmodule // ptmr_timer

//--- tb/ptmr_pin_model.sv
// far side: trigger pin driver and load on the timer pin
`timescale 1ns/1ps
module ptmr_pin_model (
   // burst request and timer pin
   input wire clk_i,
   input wire [7:0] edges_i,
   input wire go_i,
   input wire slow_i,
   input wire out_i,
   input wire out_en_i,
   // trigger pin and level at the load
   output reg pin_o,
   output wire load_o
);
   integer n;
   // released pin sits at the load pull-up
   assign load_o = out_en_i ? out_i : 1'b1;
   initial pin_o = 1'b0;
   always @(posedge clk_i) begin
      if (go_i) begin
         for (n = 0; n < edges_i; n = n + 1) begin
            repeat (slow_i ? 7 : 2) @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (slow_i ? 7 : 2) @(posedge clk_i);
            pin_o <= 1'b0;
         end
      end
   end
endmodule // ptmr_pin_model

//--- tb/ptmr_props.sv
// port checker for the periodic timer
`timescale 1ns/1ps
module ptmr_props (
   // timer ports
   input wire SYS_CLK_I,
   input wire RST_I,
   input wire [2:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   input wire [7:0] RDATA_O,
   input wire TIMER_OUT_O,
   input wire TIMER_OUT_EN_O,
   input wire CMP_A_FLAG_O,
   input wire CMP_P_FLAG_O
);
   reg [7:0] sh_ff [0:7];
   reg [3:0] q_ff;
   integer i;
   wire [7:0] c0 = sh_ff[0];
   wire [7:0] c1 = sh_ff[1];
   wire [9:0] cmpa = {sh_ff[5][1:0], sh_ff[4]};
   wire [9:0] per = {sh_ff[7][1:0], sh_ff[6]};
   wire cmpm = c1[7] == c1[6];
   wire act = c1[3] ^ c1[2];
   // shadow misses hardware clears of the on bit, so pulse mode is left alone
   always @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         for (i = 0; i < 8; i = i + 1) sh_ff[i] <= 8'h00;
         q_ff <= 4'h0;
      end else begin
         if (WR_I) sh_ff[ADDR_I] <= WDATA_I;
         q_ff <= WR_I ? 4'h0 : q_ff + {3'h0, q_ff != 4'hF};
      end
   end
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RST_I);
   property p_hi_zero;
      RD_I && ADDR_I[0] && ADDR_I != 3'h1 |=> RDATA_O[7:2] == 6'h00;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("high bits set");
   property p_en_tmr;
      cmpm |-> TIMER_OUT_EN_O == !c1[7];
   endproperty
   a_en_tmr: assert property (p_en_tmr) else $error("pin enable");
   property p_no_a;
      cmpm && cmpa == 10'h000 && !CMP_A_FLAG_O |=> !CMP_A_FLAG_O;
   endproperty
   a_no_a: assert property (p_no_a) else $error("flag A at zero");
   property p_no_p;
      cmpm && c1[0] && !CMP_P_FLAG_O |=> !CMP_P_FLAG_O;
   endproperty
   a_no_p: assert property (p_no_p) else $error("flag P raised");
   property p_hold;
      q_ff > 4'h4 && c1[7:4] == 4'h0 |-> $stable(TIMER_OUT_O);
   endproperty
   a_hold: assert property (p_hold) else $error("pin moved");
   property p_init;
      WR_I && ADDR_I == 3'h0 && WDATA_I[3] && !c0[3] && c1[7:6] == 2'b00 && !c1[2] |-> ##[1:5] TIMER_OUT_O == c1[3];
   endproperty
   a_init: assert property (p_init) else $error("no initial level");
   property p_pwm_on;
      q_ff == 4'hF && c0[3] && c1[7:6] == 2'b10 && (c1[5:4] == 2'b01 || c1[5:4] == 2'b10 && per != 10'h000 && cmpa >= per)
         |-> TIMER_OUT_O == act;
   endproperty
   a_pwm_on: assert property (p_pwm_on) else $error("not active");
   property p_pwm_off;
      q_ff == 4'hF && c0[3] && c1[7:4] == 4'h8 |-> TIMER_OUT_O == !act;
   endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("not inactive");
   c_flags: cover property (CMP_A_FLAG_O && CMP_P_FLAG_O);
   c_rise: cover property ($rose(TIMER_OUT_O));
   c_free: cover property (!TIMER_OUT_EN_O);
endmodule // ptmr_props
bind ptmr_timer ptmr_props u_props (.*);

//--- tb/periodic_timer_compare_pwm_bench.sv
// self-checking bench for the periodic timer
`timescale 1ns/1ps
module periodic_timer_compare_pwm_bench;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [2:0] addr = 3'h0;
   reg [7:0] wd = 8'h00;
   reg [7:0] edges = 8'h00;
   reg wr = 1'b0, rd = 1'b0, clra = 1'b0, clrp = 1'b0, go = 1'b0, slow = 1'b0;
   reg [7:0] v, v2;
   wire [7:0] rdat;
   wire tout, ten, fa, fp, ext, load;
   integer bad_count = 0;
   integer n_checks = 0;
   integer seed = 93;
   integer i, k, n, d, r;
   always #2.5 clk = ~clk;
   ptmr_timer #(.SUB_DIV(8)) uut (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdat), .EXT_CLK_PIN_I(ext), .TIMER_OUT_O(tout), .TIMER_OUT_EN_O(ten),
      .CMP_A_FLAG_O(fa), .CMP_P_FLAG_O(fp), .CMP_A_FLAG_CLR_I(clra), .CMP_P_FLAG_CLR_I(clrp));
   ptmr_pin_model far (.clk_i(clk), .edges_i(edges), .go_i(go), .slow_i(slow), .out_i(tout),
      .out_en_i(ten), .pin_o(ext), .load_o(load));
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
         end
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task tick(input integer t);
      begin
         repeat (t) @(posedge clk);
         #1;
      end
   endtask
   task wreg(input [2:0] a, input [7:0] dat);
      begin
         @(posedge clk);
         addr <= a;
         wd <= dat;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rreg(input [2:0] a);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 v = rdat;
      end
   endtask
   // timer off while set up, flags cleared, then switched on
   task start(input [7:0] m, input [9:0] a, input [9:0] p, input [7:0] c0);
      begin
         wreg(3'h0, 8'h00);
         wreg(3'h1, m);
         wreg(3'h4, a[7:0]);
         wreg(3'h5, {6'h00, a[9:8]});
         wreg(3'h6, p[7:0]);
         wreg(3'h7, {6'h00, p[9:8]});
         clra <= 1'b1;
         clrp <= 1'b1;
         tick(1);
         clra <= 1'b0;
         clrp <= 1'b0;
         wreg(3'h0, c0);
      end
   endtask
   initial begin
      #100000;
      bad_count = bad_count + 1;
      stop_test;
   end
   initial begin
      tick(12);
      rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         rreg(i[2:0]);
         check(v, 8'h00);
      end
      for (i = 4; i < 8; i = i + 1) begin
         r = $random(seed);
         wreg(i[2:0], r[7:0]);
         rreg(i[2:0]);
         check(v, i[0] ? {6'h00, r[1:0]} : r[7:0]);
      end
      for (i = 1; i < 4; i = i + 1) begin
         start({2'b00, i[1:0], i == 1, 3'h0}, 10'd20, 10'd40, 8'h18);
         tick(5);
         check(load, i == 1);
         tick(24);
         check(load, i != 1);
         tick(30);
         check({fa, fp}, 2'b11);
      end
      start(8'h01, 10'd30, 10'd10, 8'h18);
      tick(100);
      check({fa, fp}, 2'b10);
      rreg(3'h2);
      check(v < 8'd31, 1);
      start(8'hC0, 10'd0, 10'd0, 8'h18);
      check(load, 1);
      rreg(3'h2);
      v2 = v;
      rreg(3'h2);
      check(v - v2, 2);
      tick(1100);
      check(fa, 0);
      wreg(3'h0, 8'h10);
      rreg(3'h2);
      v2 = v;
      tick(9);
      rreg(3'h2);
      check(v, v2);
      wreg(3'h0, 8'h18);
      rreg(3'h3);
      check(v, 0);
      for (i = 0; i < 4; i = i + 1) begin
         n = i == 0 ? 4 : i == 1 ? 16 : i == 2 ? 64 : 8;
         k = i == 0 ? 8'h08 : i == 1 ? 8'h28 : i == 2 ? 8'h38 : 8'h48;
         start(8'hC0, 10'd0, 10'd0, k[7:0]);
         rreg(3'h2);
         v2 = v;
         tick(318);
         rreg(3'h2);
         check(v - v2, 320 / n);
      end
      for (i = 0; i < 6; i = i + 1) begin
         r = $random(seed);
         n = 4 + r[5:0];
         d = i == 4 ? n + 5 : 1 + r[15:8] % (n - 1);
         if (i == 5) n = 1024;
         if (i == 5) d = 512;
         start({5'b10101, r[16], 2'b00}, d[9:0], n[9:0], 8'h18);
         tick(20);
         k = 0;
         repeat (2 * n) begin
            @(posedge clk);
            #1 if (load === ~r[16]) k = k + 1;
         end
         check(k, 2 * (d < n ? d : n));
         check(fp, 1);
      end
      for (i = 0; i < 2; i = i + 1) begin
         start({3'b100, i[0], 4'h8}, 10'd10, 10'd20, 8'h18);
         tick(60);
         check(fp, 1);
      end
      start(8'hB8, 10'd10, 10'd0, 8'h18);
      tick(4);
      check(load, 1);
      tick(20);
      check(load, 0);
      rreg(3'h0);
      check({v[3], fa}, 2'b01);
      rreg(3'h2);
      v2 = v;
      rreg(3'h2);
      check(v, v2);
      for (i = 0; i < 2; i = i + 1) begin
         // rising-edge pin source first, then falling-edge
         wreg(3'h0, i[0] ? 8'h70 : 8'h60);
         edges <= 8'd1;
         slow <= i == 0;
         go <= 1'b1;
         tick(1);
         go <= 1'b0;
         tick(30);
         rreg(3'h0);
         check(v[3], 1);
         wreg(3'h0, 8'h18);
         tick(30);
         rreg(3'h0);
         check(v[3], 0);
      end
      stop_test;
   end
endmodule // periodic_timer_compare_pwm_bench
